// file: design/clk_out_drv_pkg.sv
// Package for the clock output driver control bank.
// Assumes one clock domain and a plain register port with a one-cycle read latency.
package clk_out_drv_pkg;

    // Register offsets, byte addresses on an 8-bit register port
    localparam logic [7:0] OUTPUT_ENABLE_BITS_OFS     = 8'h39;
    localparam logic [7:0] OUTPUT_POLARITY_OFS        = 8'h3A;
    localparam logic [7:0] RESERVED_DRIVER_A_OFS      = 8'h3B;
    localparam logic [7:0] RESERVED_DRIVER_B_OFS      = 8'h3C;
    localparam logic [7:0] DRIVER_STYLE_PAIRS_3_2_OFS = 8'h3D;
    localparam logic [7:0] DRIVER_STYLE_PAIRS_1_0_OFS = 8'h3E;

    // Field positions
    localparam int PAIR_ENABLE_LSB      = 0;
    localparam int POLARITY_INVERT_BIT  = 3;
    localparam int PAIR3_STYLE_LSB      = 5;
    localparam int PAIR3_SE_PHASE_BIT   = 4;
    localparam int PAIR2_STYLE_LSB      = 1;
    localparam int PAIR1_STYLE_LSB      = 5;
    localparam int PAIR0_STYLE_LSB      = 1;

    // Reset values
    localparam logic [3:0] PAIR_ENABLE_RST   = 4'h0;
    localparam logic       POLARITY_RST      = 1'b0;
    localparam logic [2:0] DRIVER_STYLE_RST  = 3'h1;
    localparam logic       SE_PHASE_RST      = 1'b0;

    // Driver styles, as written in the style fields
    localparam logic [2:0] STYLE_HIZ  = 3'h0;
    localparam logic [2:0] STYLE_PECL = 3'h1;
    localparam logic [2:0] STYLE_LVDS = 3'h2;
    localparam logic [2:0] STYLE_CMOS = 3'h3;
    localparam logic [2:0] STYLE_HCSL = 3'h4;

    // Decoded driver state, one-hot
    typedef enum logic [5:0] {
        DRV_OFF  = 6'h01,
        DRV_PECL = 6'h02,
        DRV_LVDS = 6'h04,
        DRV_CMOS = 6'h08,
        DRV_HCSL = 6'h10,
        DRV_RSVD = 6'h20
    } drv_state_e;

endpackage : clk_out_drv_pkg

// file: design/pair_driver_decode.sv
// Decoder for one output pair: enable, style, polarity and phase mode.
// Assumes the style field and the clock come from the register bank and the divider.
`timescale 1ns/1ps
module pair_driver_decode #(
    parameter bit HAS_CMOS = 1'b0 // Only the fourth pair offers CMOS
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       enable,
    input  wire logic [2:0] style,
    input  wire logic       invert,
    input  wire logic       same_phase,
    input  wire logic       clk_in,
    output logic            true_out,
    output logic            comp_out,
    output logic            true_oe,
    output logic            comp_oe,
    output logic [5:0]      drv_state
);

    clk_out_drv_pkg::drv_state_e state_next; // Combinational decoded state
    clk_out_drv_pkg::drv_state_e state_reg;  // Registered decoded state

    // Style decode; a reserved code leaves the pins floating as a safe default
    always_comb begin
        if (!enable) begin
            state_next = clk_out_drv_pkg::DRV_OFF;
        end else begin
            case (style)
                clk_out_drv_pkg::STYLE_HIZ:  state_next = clk_out_drv_pkg::DRV_OFF;
                clk_out_drv_pkg::STYLE_PECL: state_next = clk_out_drv_pkg::DRV_PECL;
                clk_out_drv_pkg::STYLE_LVDS: state_next = clk_out_drv_pkg::DRV_LVDS;
                clk_out_drv_pkg::STYLE_CMOS: begin
                    // Only the top pair may take the CMOS code; elsewhere it is refused
                    if (HAS_CMOS) begin
                        state_next = clk_out_drv_pkg::DRV_CMOS;
                    end else begin
                        state_next = clk_out_drv_pkg::DRV_RSVD;
                    end
                end
                clk_out_drv_pkg::STYLE_HCSL: state_next = clk_out_drv_pkg::DRV_HCSL;
                default:                     state_next = clk_out_drv_pkg::DRV_RSVD;
            endcase
        end
    end

    // Registered so that the pin enables never glitch on a register write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= clk_out_drv_pkg::DRV_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    logic driving; // Pair drives its pins in any valid style
    assign driving   = (state_reg != clk_out_drv_pkg::DRV_OFF) && (state_reg != clk_out_drv_pkg::DRV_RSVD);
    assign true_oe   = driving;
    assign comp_oe   = driving;
    assign drv_state = state_reg;

    // Pin levels; the phase mode only matters in CMOS style
    logic base_clk; // Clock after optional inversion
    assign base_clk = clk_in ^ invert;
    assign true_out = driving & base_clk;
    assign comp_out = driving & ((state_reg == clk_out_drv_pkg::DRV_CMOS && same_phase) ? base_clk
                                                                                        : ~base_clk);

endmodule : pair_driver_decode

// file: design/clock_output_driver_control.sv
// Register bank and pin control for four clock output pairs.
// Assumes a synchronous register port and divided clocks supplied per pair.
`timescale 1ns/1ps
module clock_output_driver_control #(
    parameter int PAIRS = 4 // Number of output pairs; the map is built for four
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic [PAIRS-1:0] pair_clk,
    output logic      [PAIRS-1:0] clock_out_true,
    output logic      [PAIRS-1:0] clock_out_complement,
    output logic      [PAIRS-1:0] clock_out_true_oe,
    output logic      [PAIRS-1:0] clock_out_complement_oe
);

    // The register map has fixed room for exactly four pairs
    if (PAIRS != 4) begin : g_bad_pairs
        $error("PAIRS must be 4");
    end

    logic [3:0] pair_enable_bits_reg;        // One enable per pair
    logic       pair3_polarity_invert_reg;   // Fourth pair polarity
    logic       pair3_single_ended_phase_reg;// Fourth pair CMOS phase mode
    logic [2:0] pair3_driver_style_reg;      // Style fields
    logic [2:0] pair2_driver_style_reg;
    logic [2:0] pair1_driver_style_reg;
    logic [2:0] pair0_driver_style_reg;
    logic [7:0] rdata_next;                  // Read mux output
    logic [7:0] rdata_reg;                   // Read data, one cycle late

    // Enable bits; reserved bits are not stored, so they read as zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pair_enable_bits_reg <= clk_out_drv_pkg::PAIR_ENABLE_RST;
        end else if (reg_wr && reg_addr == clk_out_drv_pkg::OUTPUT_ENABLE_BITS_OFS) begin
            pair_enable_bits_reg <= reg_wdata[clk_out_drv_pkg::PAIR_ENABLE_LSB +: 4];
        end
    end

    // Polarity of the fourth pair
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pair3_polarity_invert_reg <= clk_out_drv_pkg::POLARITY_RST;
        end else if (reg_wr && reg_addr == clk_out_drv_pkg::OUTPUT_POLARITY_OFS) begin
            pair3_polarity_invert_reg <= reg_wdata[clk_out_drv_pkg::POLARITY_INVERT_BIT];
        end
    end

    // Styles of pairs 3 and 2, plus the phase mode bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pair3_driver_style_reg       <= clk_out_drv_pkg::DRIVER_STYLE_RST;
            pair2_driver_style_reg       <= clk_out_drv_pkg::DRIVER_STYLE_RST;
            pair3_single_ended_phase_reg <= clk_out_drv_pkg::SE_PHASE_RST;
        end else if (reg_wr && reg_addr == clk_out_drv_pkg::DRIVER_STYLE_PAIRS_3_2_OFS) begin
            pair3_driver_style_reg       <= reg_wdata[clk_out_drv_pkg::PAIR3_STYLE_LSB +: 3];
            pair2_driver_style_reg       <= reg_wdata[clk_out_drv_pkg::PAIR2_STYLE_LSB +: 3];
            pair3_single_ended_phase_reg <= reg_wdata[clk_out_drv_pkg::PAIR3_SE_PHASE_BIT];
        end
    end

    // Styles of pairs 1 and 0
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pair1_driver_style_reg <= clk_out_drv_pkg::DRIVER_STYLE_RST;
            pair0_driver_style_reg <= clk_out_drv_pkg::DRIVER_STYLE_RST;
        end else if (reg_wr && reg_addr == clk_out_drv_pkg::DRIVER_STYLE_PAIRS_1_0_OFS) begin
            pair1_driver_style_reg <= reg_wdata[clk_out_drv_pkg::PAIR1_STYLE_LSB +: 3];
            pair0_driver_style_reg <= reg_wdata[clk_out_drv_pkg::PAIR0_STYLE_LSB +: 3];
        end
    end

    // Read mux; reserved and unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr)
            clk_out_drv_pkg::OUTPUT_ENABLE_BITS_OFS:
                rdata_next[clk_out_drv_pkg::PAIR_ENABLE_LSB +: 4] = pair_enable_bits_reg;
            clk_out_drv_pkg::OUTPUT_POLARITY_OFS:
                rdata_next[clk_out_drv_pkg::POLARITY_INVERT_BIT] = pair3_polarity_invert_reg;
            clk_out_drv_pkg::DRIVER_STYLE_PAIRS_3_2_OFS: begin
                rdata_next[clk_out_drv_pkg::PAIR3_STYLE_LSB +: 3]  = pair3_driver_style_reg;
                rdata_next[clk_out_drv_pkg::PAIR3_SE_PHASE_BIT]    = pair3_single_ended_phase_reg;
                rdata_next[clk_out_drv_pkg::PAIR2_STYLE_LSB +: 3]  = pair2_driver_style_reg;
            end
            clk_out_drv_pkg::DRIVER_STYLE_PAIRS_1_0_OFS: begin
                rdata_next[clk_out_drv_pkg::PAIR1_STYLE_LSB +: 3]  = pair1_driver_style_reg;
                rdata_next[clk_out_drv_pkg::PAIR0_STYLE_LSB +: 3]  = pair0_driver_style_reg;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;

    // Per-pair style vector gathered for the generate loop
    logic [2:0] style_vec [PAIRS];
    logic [5:0] state_vec [PAIRS]; // Decoded state, watched by assertions
    assign style_vec[0] = pair0_driver_style_reg;
    assign style_vec[1] = pair1_driver_style_reg;
    assign style_vec[2] = pair2_driver_style_reg;
    assign style_vec[3] = pair3_driver_style_reg;

    // One decoder per pair; only the top pair gets CMOS, polarity and phase
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
        localparam bit TOP = (p == PAIRS - 1);
        pair_driver_decode #(
            .HAS_CMOS (TOP)
        ) u_decode (
            .clk_sys    (clk_sys),
            .resetn     (resetn),
            .enable     (pair_enable_bits_reg[p]),
            .style      (style_vec[p]),
            .invert     (TOP ? pair3_polarity_invert_reg : 1'b0),
            .same_phase (TOP ? pair3_single_ended_phase_reg : 1'b0),
            .clk_in     (pair_clk[p]),
            .true_out   (clock_out_true[p]),
            .comp_out   (clock_out_complement[p]),
            .true_oe    (clock_out_true_oe[p]),
            .comp_oe    (clock_out_complement_oe[p]),
            .drv_state  (state_vec[p])
        );
    end

    // Checks; the pin enables lag the registers by one edge, so most checks look one edge ahead

    // A pair whose enable was clear one edge ago must not drive
    a_enable_off_hiz: assert property (@(posedge clk_sys) disable iff (!resetn)
        !$past(pair_enable_bits_reg[0]) |-> !clock_out_true_oe[0])
        else $error("disabled pair 0 still driving");

    // An enabled pair in a valid style drives both pins
    a_enable_on_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        pair_enable_bits_reg[1] && pair1_driver_style_reg == clk_out_drv_pkg::STYLE_LVDS
        |=> clock_out_true_oe[1] && clock_out_complement_oe[1])
        else $error("enabled LVDS pair 1 not driving");

    // Polarity bit flips the true pin of the top pair
    a_polarity_invert: assert property (@(posedge clk_sys) disable iff (!resetn)
        clock_out_true_oe[3] |-> clock_out_true[3] == (pair_clk[3] ^ pair3_polarity_invert_reg))
        else $error("pair 3 polarity wrong");

    // The top pair accepts the CMOS code
    a_top_cmos_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        pair_enable_bits_reg[3] && pair3_driver_style_reg == clk_out_drv_pkg::STYLE_CMOS
        |=> state_vec[3] == 6'h08)
        else $error("pair 3 CMOS not decoded");

    // A low pair given the CMOS code stays undriven
    a_low_cmos_rsvd: assert property (@(posedge clk_sys) disable iff (!resetn)
        pair0_driver_style_reg == clk_out_drv_pkg::STYLE_CMOS |=> !clock_out_true_oe[0])
        else $error("pair 0 drives reserved CMOS code");

    // CMOS with the phase bit clear: pins in opposite phase
    a_cmos_opposite: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_vec[3] == 6'h08 && !pair3_single_ended_phase_reg
        |-> clock_out_complement[3] != clock_out_true[3])
        else $error("CMOS pins not opposite");

    // CMOS with the phase bit set: pins in equal phase
    a_cmos_same: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_vec[3] == 6'h08 && pair3_single_ended_phase_reg
        |-> clock_out_complement[3] == clock_out_true[3])
        else $error("CMOS pins not equal phase");

    // An enable write read back with no gap returns the written bits
    a_readback_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && reg_addr == clk_out_drv_pkg::OUTPUT_ENABLE_BITS_OFS ##1
        reg_rd && reg_addr == clk_out_drv_pkg::OUTPUT_ENABLE_BITS_OFS
        |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
        else $error("enable readback mismatch");

    // A style write read back with no gap returns all stored fields; bit 0 is not stored
    a_readback_styles: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && reg_addr == clk_out_drv_pkg::DRIVER_STYLE_PAIRS_3_2_OFS ##1
        reg_rd && reg_addr == clk_out_drv_pkg::DRIVER_STYLE_PAIRS_3_2_OFS
        |=> reg_rdata == {$past(reg_wdata[7:1], 2), 1'b0})
        else $error("style readback mismatch");

    // Per-pair checks, so that no single pair slips through unwatched
    for (genvar q = 0; q < PAIRS; q++) begin : g_pair_chk
        // A cleared enable floats both pins one edge later, whatever the style
        a_pair_disable_float: assert property (@(posedge clk_sys) disable iff (!resetn)
            !pair_enable_bits_reg[q]
            |=> !clock_out_true_oe[q] && !clock_out_complement_oe[q])
            else $error("disabled pair still driving");
        // Only the low pairs refuse the CMOS code
        if (q < PAIRS - 1) begin : g_low
            a_low_cmos_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
                style_vec[q] == clk_out_drv_pkg::STYLE_CMOS
                |=> !clock_out_true_oe[q] && !clock_out_complement_oe[q])
                else $error("low pair drives reserved CMOS code");
        end
    end

    // Main scenarios worth seeing at least once
    c_enable_write: cover property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && reg_addr == clk_out_drv_pkg::OUTPUT_ENABLE_BITS_OFS);
    c_cmos_same: cover property (@(posedge clk_sys) disable iff (!resetn)
        state_vec[3] == 6'h08 && pair3_single_ended_phase_reg);
    c_hcsl_drive: cover property (@(posedge clk_sys) disable iff (!resetn)
        state_vec[2] == 6'h10);
    c_write_then_read: cover property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr ##1 reg_rd);
    c_low_refused: cover property (@(posedge clk_sys) disable iff (!resetn)
        state_vec[0] == 6'h20);

endmodule : clock_output_driver_control

// file: tb/clock_output_driver_control_tb.sv
// Self-checking bench for the clock output driver control bank.
// Assumes the plain register port with one-cycle read data and registered pin enables.
`timescale 1ns/1ps
module clock_output_driver_control_tb;
    typedef struct {string what; logic [15:0] val;} note_s;
    logic       clk_sys, resetn, reg_wr, reg_rd;  // Clock, reset, strobes
    logic [7:0] reg_addr, reg_wdata, reg_rdata;   // Register port
    logic [3:0] pair_clk, clock_out_true, clock_out_complement;
    logic [3:0] clock_out_true_oe, clock_out_complement_oe;
    note_s      notes[$];                         // Expected results, oldest first
    int         bad_count, n_checks;              // Mismatch and comparison counts
    logic       rd_d, pin_chk;                    // Read answer due; pin probe
    logic [7:0] rnd;                              // Random source state
    logic [3:0] en_sh;                            // Shadow of the enable bits
    logic       inv_sh, same_sh;                  // Shadow of polarity and phase bits
    logic [2:0] sty_sh[4];                        // Shadow of the style fields
    // Compare one value, report and count
    `define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
        $display("wrong value %s expected %h seen %h", w, e, g); end end

    clock_output_driver_control #(.PAIRS(4)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair_clk(pair_clk),
        .clock_out_true(clock_out_true), .clock_out_complement(clock_out_complement),
        .clock_out_true_oe(clock_out_true_oe), .clock_out_complement_oe(clock_out_complement_oe));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Eight-bit feedback shift register
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr_next

    // Expected {true_oe, comp_oe, true, comp}; undriven pins sit at 0
    function automatic logic [15:0] pin_exp(input logic [3:0] c);
        logic [3:0] oe, t, cm;
        for (int i = 0; i < 4; i++) begin
            oe[i] = en_sh[i] && ((sty_sh[i] inside {3'h1, 3'h2, 3'h4}) || (i == 3 && sty_sh[i] == 3'h3));
            t[i]  = oe[i] & (c[i] ^ (i == 3 && inv_sh));
            cm[i] = oe[i] & ((i == 3 && same_sh && sty_sh[3] == 3'h3) ? t[i] : ~t[i]);
        end
        return {oe, oe, t, cm};
    endfunction : pin_exp

    // Shadow follows the reset values of the bank
    task automatic shadow_reset();
        en_sh = 4'h0; inv_sh = 1'b0; same_sh = 1'b0;
        for (int i = 0; i < 4; i++) sty_sh[i] = 3'h1;
    endtask : shadow_reset

    // The shadow tracks defined fields only
    task automatic shadow_write(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h39: en_sh = d[3:0];
            8'h3A: inv_sh = d[3];
            8'h3D: begin sty_sh[3] = d[7:5]; same_sh = d[4]; sty_sh[2] = d[3:1]; end
            8'h3E: begin sty_sh[1] = d[7:5]; sty_sh[0] = d[3:1]; end
            default: ;
        endcase
    endtask : shadow_write

    // One-cycle write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        shadow_write(a, d);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Write then read of one place with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input string w);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        shadow_write(a, d);
        @(posedge clk_sys);
        notes.push_back('{w, {8'h00, e}});
        reg_wr <= 1'b0; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : wr_rd

    // One-cycle read; the expected answer is noted first
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
        @(posedge clk_sys);
        notes.push_back('{w, {8'h00, e}});
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd

    // Let the registered enables settle, then present random clocks and probe the pins
    task automatic pins(input string w);
        repeat (2) @(posedge clk_sys);
        rnd = lfsr_next(rnd);
        notes.push_back('{w, pin_exp(rnd[3:0])});
        pair_clk <= rnd[3:0]; pin_chk <= 1'b1;
        @(posedge clk_sys);
        pin_chk <= 1'b0;
    endtask : pins

    // Verdict in one place
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // Read answers are due in the cycle after the strobe
    always @(posedge clk_sys) rd_d <= reg_rd;

    // Watcher: takes the oldest note whenever a result shows
    always @(negedge clk_sys) begin
        if (rd_d || pin_chk) begin
            note_s n;
            if (notes.size() == 0) n = '{"unnoted result", 16'hFFFF};
            else n = notes.pop_front();
            if (rd_d) `CHK(n.what, n.val, {8'h00, reg_rdata})
            else `CHK(n.what, n.val, {clock_out_true_oe, clock_out_complement_oe, clock_out_true, clock_out_complement})
        end
    end

    // Hang guard, far beyond the roughly 170 cycles the run needs
    initial begin
        #50us;
        bad_count++;
        close_out();
    end

    // Main sequence
    initial begin
        resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        pair_clk = 4'h0; pin_chk = 1'b0; rnd = 8'h54; bad_count = 0; n_checks = 0;
        shadow_reset();
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values, reserved place 3B included
        rd(8'h39, 8'h00, "enable reset");
        rd(8'h3A, 8'h00, "polarity reset");
        rd(8'h3B, 8'h00, "reserved a");
        rd(8'h3D, 8'h22, "styles 3 2 reset");
        rd(8'h3E, 8'h22, "styles 1 0 reset");
        pins("pins after reset");
        $display("test reset done");
        // Every style code on every pair, all pairs enabled
        wr(8'h39, 8'h0F);
        pins("pins enabled pecl");
        for (int s = 0; s < 8; s++) begin
            wr(8'h3E, {s[2:0], 1'b0, s[2:0], 1'b0});
            wr_rd(8'h3D, {s[2:0], 1'b0, s[2:0], 1'b0}, {s[2:0], 1'b0, s[2:0], 1'b0}, "styles 3 2");
            pins("pins per style");
        end
        $display("test styles done");
        // Polarity and both phase modes of the fourth pair
        wr(8'h3A, 8'h08);
        wr(8'h3D, 8'h74);
        rd(8'h3A, 8'h08, "polarity");
        pins("cmos same phase inverted");
        wr(8'h3D, 8'h64);
        pins("cmos opposite phase inverted");
        wr(8'h3A, 8'h00);
        wr(8'h3D, 8'h24);
        pins("pecl normal polarity");
        $display("test polarity done");
        // Random enables, read back at once
        repeat (6) begin
            rnd = lfsr_next(rnd);
            wr_rd(8'h39, {4'h0, rnd[3:0]}, {4'h0, rnd[3:0]}, "random enables");
            pins("pins random enables");
        end
        $display("test random done");
        // Reserved places get zeros only, as software must; unmapped places hold nothing
        wr(8'h3B, 8'h00);
        wr(8'h3C, 8'h00);
        wr(8'h50, 8'hFF);
        rd(8'h3B, 8'h00, "reserved a write");
        rd(8'h3C, 8'h00, "reserved b write");
        rd(8'h50, 8'h00, "unmapped read");
        rd(8'h39, {4'h0, en_sh}, "enable kept");
        $display("test reserved done");
        // Reset in mid-run clears the bank again
        @(posedge clk_sys);
        resetn <= 1'b0;
        shadow_reset();
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(8'h39, 8'h00, "enable after reset");
        pins("pins after second reset");
        $display("test second reset done");
        repeat (2) @(posedge clk_sys);
        close_out();
    end
endmodule : clock_output_driver_control_tb
